// ---- rvpc_pkg.sv ----
// constants, types and register map of the rail voltage power control block
package rvpc_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned PING_WAIT_MS = 70; // wait for a strength reply
	localparam int unsigned PING_OFF_MS = 20; // signal removed between pings
	localparam int unsigned PING_WAIT_CYC = (CLK_HZ / 1000) * PING_WAIT_MS;
	localparam int unsigned PING_OFF_CYC = (CLK_HZ / 1000) * PING_OFF_MS;

	// ------------------------------------------------------------
	// rail voltage, in half-millivolt units
	// ------------------------------------------------------------
	localparam int unsigned RAIL_W = 15;
	localparam logic [14:0] RAIL_MIN_HMV = 15'd6000; // 3 V
	localparam logic [14:0] RAIL_MAX_HMV = 15'd24000; // 12 V
	localparam logic [14:0] RAIL_PING_HMV = 15'd11400; // 5.7 V

	// ------------------------------------------------------------
	// switching frequency, in kHz
	// ------------------------------------------------------------
	localparam logic [7:0] FREQ_PING_KHZ = 8'd140;
	localparam logic [7:0] FREQ_MIN_KHZ = 8'd105;

	// ------------------------------------------------------------
	// control loop
	// ------------------------------------------------------------
	localparam int PROP_GAIN = 1;
	localparam int INTEGRAL_GAIN = 0; // no integral path is built
	localparam int DERIVATIVE_GAIN = 0; // no derivative path is built
	localparam int LOOP_OUTPUT_LIMIT = 1500;
	localparam int SCALE_HMV = -1; // -0.5 mV per loop unit

	// ------------------------------------------------------------
	// register map and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TARGET = 8'h04;
	localparam logic [7:0] ADDR_SS_MIN = 8'h08;
	localparam logic [7:0] ADDR_FSTEP = 8'h0C;
	localparam logic [7:0] ADDR_TRIES = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_RAIL = 8'h18;
	localparam logic [7:0] ADDR_COIL = 8'h1C;
	localparam logic [7:0] ADDR_GUIDE = 8'h20;
	localparam logic [13:0] TARGET_RST = 14'd2000;
	localparam logic [7:0] SS_MIN_RST = 8'h01;
	localparam logic [7:0] FSTEP_RST = 8'h05;
	localparam logic [3:0] TRIES_RST = 4'h7;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_PING = 2'b01,
		S_OFF = 2'b10,
		S_XFER = 2'b11
	} rvpc_state_e;

	typedef struct packed {
		rvpc_state_e st;
		logic [31:0] cnt;
		logic [14:0] rail;
		logic [7:0] freq;
		logic pwr;
		logic [3:0] tries;
		logic fail;
		logic [7:0] ss_last;
		logic [13:0] meas;
		logic [13:0] target;
		logic [7:0] ss_min;
		logic [7:0] fstep;
		logic [3:0] max_tries;
		logic [1:0] guide;
		logic [1:0] guide_out;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rvpc_state_s;

endpackage

// ---- rvpc_top.sv ----
// rail voltage power control: ping sequence, voltage loop and APB registers
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// R1 - transferred power is set by the inverter rail command, held between 3 V and 12 V.
// R2 - the rail command moves in 0.5 mV units, finer than 50 mV.
// R3 - each first application of the power signal uses a 5.7 V rail.
// R4 - the first ping runs at 140 kHz.
// R5 - without a strength reply in the wait time the power signal is removed.
// R6 - pings repeat at successively lower frequencies until a good strength reply arrives, the retry count is used up or the next step would pass 105 kHz.
// R7 - every switching frequency lies between 105 kHz and 140 kHz.
// R8 - during transfer a loop whose controlled variable is the rail voltage sets power.
// R9 - the coil voltage amplitude is taken with 1 mV resolution for the loop.
// R10 - the loop uses proportional gain 1 and no integral or derivative term.
// R11 - the loop output is clamped to 1500 and scaled by -0.5 mV per unit.
// R12 - a two-direction guide indicator steers the user onto the active area.
// R13 - the loop feedback is the sensed primary coil voltage.
// R14 - each loop result is saturated to the 3 V to 12 V span before use.
module rvpc_top
	import rvpc_pkg::*;
#(
	parameter int unsigned PING_WAIT_CYCLES = PING_WAIT_CYC,
	parameter int unsigned PING_OFF_CYCLES = PING_OFF_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [13:0] coil_mv,
	input wire logic coil_vld,
	input wire logic ss_vld,
	input wire logic [7:0] ss_value,
	output logic [14:0] rail_hmv,
	output logic [7:0] freq_khz,
	output logic pwr_on,
	output logic [1:0] guide_ind
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// address decode of the register map
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == ADDR_CTRL) || (a == ADDR_TARGET) || (a == ADDR_SS_MIN)
			|| (a == ADDR_FSTEP) || (a == ADDR_TRIES) || (a == ADDR_STATUS)
			|| (a == ADDR_RAIL) || (a == ADDR_COIL) || (a == ADDR_GUIDE);
	endfunction

	// one loop step: error, gain, clamp, scale, then rail saturation
	function automatic logic [14:0] loop_step(
		input logic [14:0] rail,
		input logic [13:0] target,
		input logic [13:0] meas
	);
		logic signed [17:0] err;
		logic signed [17:0] pid;
		logic signed [17:0] v;
		err = $signed({4'h0, target}) - $signed({4'h0, meas});
		pid = err * 18'(PROP_GAIN);
		if (pid > 18'(LOOP_OUTPUT_LIMIT)) begin
			pid = 18'(LOOP_OUTPUT_LIMIT); // see R11
		end else if (pid < -18'(LOOP_OUTPUT_LIMIT)) begin
			pid = -18'(LOOP_OUTPUT_LIMIT); // see R11
		end
		v = $signed({3'b000, rail}) + pid * 18'(SCALE_HMV); // see R11
		if (v < $signed({3'b000, RAIL_MIN_HMV})) begin
			loop_step = RAIL_MIN_HMV; // see R14
		end else if (v > $signed({3'b000, RAIL_MAX_HMV})) begin
			loop_step = RAIL_MAX_HMV; // see R14
		end else begin
			loop_step = v[14:0];
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	rvpc_state_s r_q;
	rvpc_state_s r_d;
	logic acc;
	logic wr_done;
	logic ss_good;
	logic [7:0] next_freq;
	logic can_retry;

	// bus phase decode and ping helpers
	assign acc = psel && penable && !r_q.pready;
	assign wr_done = psel && penable && r_q.pready && pwrite && addr_hit(paddr);
	assign ss_good = ss_vld && (ss_value >= r_q.ss_min);
	assign next_freq = r_q.freq - r_q.fstep;
	// nine-bit sum so a large step cannot wrap and allow a retry below the floor
	assign can_retry = (r_q.tries < r_q.max_tries) && (r_q.fstep != 8'h00)
		&& ({1'b0, r_q.freq} >= ({1'b0, FREQ_MIN_KHZ} + {1'b0, r_q.fstep})); // see R7

	// next-state logic for bus, sequence and loop
	always_comb begin
		r_d = r_q;
		r_d.pready = acc;
		if (acc) begin
			r_d.pslverr = !addr_hit(paddr);
			r_d.prdata = 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					ADDR_TARGET: r_d.prdata = {18'h0_0000, r_q.target};
					ADDR_SS_MIN: r_d.prdata = {24'h00_0000, r_q.ss_min};
					ADDR_FSTEP: r_d.prdata = {24'h00_0000, r_q.fstep};
					ADDR_TRIES: r_d.prdata = {28'h000_0000, r_q.max_tries};
					ADDR_STATUS: r_d.prdata = {4'h0, r_q.ss_last, r_q.freq,
						3'b000, r_q.fail, r_q.tries, r_q.pwr, 1'b0, r_q.st};
					ADDR_RAIL: r_d.prdata = {17'h0_0000, r_q.rail};
					ADDR_COIL: r_d.prdata = {18'h0_0000, r_q.meas};
					ADDR_GUIDE: r_d.prdata = {30'h0000_0000, r_q.guide};
					default: r_d.prdata = 32'h0000_0000;
				endcase
			end
		end
		// register writes take effect at the completing edge
		if (wr_done) begin
			unique case (paddr)
				ADDR_TARGET: r_d.target = pwdata[13:0];
				ADDR_SS_MIN: r_d.ss_min = pwdata[7:0];
				ADDR_FSTEP: r_d.fstep = pwdata[7:0];
				ADDR_TRIES: r_d.max_tries = pwdata[3:0];
				ADDR_GUIDE: r_d.guide = pwdata[1:0];
				default: r_d.guide = r_d.guide;
			endcase
		end
		// coil voltage sample, 1 mV per count
		if (coil_vld) begin
			r_d.meas = coil_mv; // see R9, R13
		end
		if (ss_vld) begin
			r_d.ss_last = ss_value;
		end
		// ping sequence and regulation
		unique case (r_q.st)
			S_IDLE: begin
				if (wr_done && paddr == ADDR_CTRL && pwdata[0]) begin
					r_d.st = S_PING;
					r_d.pwr = 1'b1;
					r_d.rail = RAIL_PING_HMV; // see R3
					r_d.freq = FREQ_PING_KHZ; // see R4
					r_d.tries = 4'h0;
					r_d.fail = 1'b0;
					r_d.cnt = 32'h0000_0000;
				end
			end
			S_PING: begin
				r_d.cnt = r_q.cnt + 32'h0000_0001;
				if (ss_good) begin
					r_d.st = S_XFER; // see R6
					r_d.cnt = 32'h0000_0000;
				end else if (r_q.cnt >= 32'(PING_WAIT_CYCLES - 1)) begin
					r_d.pwr = 1'b0; // see R5
					r_d.cnt = 32'h0000_0000;
					if (can_retry) begin
						r_d.st = S_OFF;
					end else begin
						r_d.st = S_IDLE;
						r_d.fail = 1'b1;
					end
				end
			end
			S_OFF: begin
				r_d.cnt = r_q.cnt + 32'h0000_0001;
				if (r_q.cnt >= 32'(PING_OFF_CYCLES - 1)) begin
					r_d.st = S_PING;
					r_d.pwr = 1'b1;
					r_d.rail = RAIL_PING_HMV; // see R3
					r_d.freq = next_freq; // see R6, R7
					r_d.tries = r_q.tries + 4'h1;
					r_d.cnt = 32'h0000_0000;
				end
			end
			S_XFER: begin
				if (coil_vld) begin
					r_d.rail = loop_step(r_q.rail, r_q.target, coil_mv); // see R8, R10
				end
			end
		endcase
		// stop command from any state
		if (wr_done && paddr == ADDR_CTRL && pwdata[1]) begin
			r_d.st = S_IDLE;
			r_d.pwr = 1'b0;
			r_d.cnt = 32'h0000_0000;
		end
		// guide shows software direction in every state except transfer
		r_d.guide_out = (r_d.st == S_XFER) ? 2'b00 : r_d.guide; // see R12
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= '{st: S_IDLE, cnt: 32'h0000_0000, rail: RAIL_PING_HMV,
				freq: FREQ_PING_KHZ, pwr: 1'b0, tries: 4'h0, fail: 1'b0,
				ss_last: 8'h00, meas: 14'h0000, target: TARGET_RST,
				ss_min: SS_MIN_RST, fstep: FSTEP_RST, max_tries: TRIES_RST,
				guide: 2'b00, guide_out: 2'b00, prdata: 32'h0000_0000,
				pready: 1'b0, pslverr: 1'b0};
		end else begin
			r_q <= r_d;
		end
	end

	// outputs straight from the state register
	assign prdata = r_q.prdata;
	assign pready = r_q.pready;
	assign pslverr = r_q.pslverr;
	assign rail_hmv = r_q.rail;
	assign freq_khz = r_q.freq;
	assign pwr_on = r_q.pwr;
	assign guide_ind = r_q.guide_out;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	AST_RAIL_SPAN: assert property (@(posedge clk) disable iff (!rst_n) // see R1
		r_q.pwr |-> (r_q.rail >= RAIL_MIN_HMV && r_q.rail <= RAIL_MAX_HMV))
		else $error("rail command outside 3 V to 12 V");
	AST_PING_RAIL: assert property (@(posedge clk) disable iff (!rst_n) // see R3
		$rose(r_q.pwr) |-> r_q.rail == RAIL_PING_HMV)
		else $error("ping did not start at 5.7 V");
	AST_PING_FREQ: assert property (@(posedge clk) disable iff (!rst_n) // see R4
		$rose(r_q.pwr) && r_q.tries == 4'h0 |-> r_q.freq == FREQ_PING_KHZ)
		else $error("first ping not at 140 kHz");
	AST_NO_REPLY_OFF: assert property (@(posedge clk) disable iff (!rst_n) // see R5
		r_q.st == S_PING && !ss_good && !wr_done
		&& r_q.cnt == 32'(PING_WAIT_CYCLES - 1) |=> !r_q.pwr)
		else $error("power not removed after silent ping");
	AST_RETRY_LOWER: assert property (@(posedge clk) disable iff (!rst_n) // see R6
		r_q.st == S_PING && $past(r_q.st) == S_OFF |-> r_q.freq < $past(r_q.freq))
		else $error("retry frequency not lower than the last ping");
	AST_RETRY_STEP: assert property (@(posedge clk) disable iff (!rst_n) // see R6
		$rose(r_q.pwr) && r_q.tries != 4'h0 |-> r_q.freq == $past(r_q.freq) - r_q.fstep)
		else $error("retry frequency not lowered by one step");
	AST_FREQ_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // see R7
		r_q.pwr |-> (r_q.freq >= FREQ_MIN_KHZ && r_q.freq <= FREQ_PING_KHZ))
		else $error("switching frequency out of range");
	AST_GOOD_REPLY: assert property (@(posedge clk) disable iff (!rst_n) // see R6
		r_q.st == S_PING && ss_good && !wr_done |=> r_q.st == S_XFER && r_q.pwr)
		else $error("good strength reply did not start transfer");
	AST_LOOP_STEP: assert property (@(posedge clk) disable iff (!rst_n) // see R11
		r_q.st == S_XFER && $past(r_q.st) == S_XFER && $past(coil_vld)
		|-> (r_q.rail + 15'd1500 >= $past(r_q.rail)) && (r_q.rail <= $past(r_q.rail) + 15'd1500))
		else $error("loop step larger than 1500 units");
	AST_LOOP_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // see R8
		r_q.st == S_XFER && !coil_vld |=> r_q.rail == $past(r_q.rail))
		else $error("rail moved without a coil sample");
	AST_GUIDE: assert property (@(posedge clk) disable iff (!rst_n) // see R12
		r_q.st != S_XFER && $stable(r_q.guide) ##1 r_q.st != S_XFER |-> guide_ind == r_q.guide)
		else $error("guide indicator not following its register");

endmodule

// ---- rvpc_rx_model.sv ----
// receiver model across the coil link: strength replies and coil readings
`timescale 1ns/100ps
module rvpc_rx_model #(
	parameter int REPLY_DLY = 10
) (
	input wire logic clk,
	input wire logic pwr_on,
	input wire logic [7:0] reply_val,
	output logic ss_vld,
	output logic [7:0] ss_value,
	output logic [13:0] coil_mv,
	output logic coil_vld
);
	// ------------------------------------------------------------
	// strength reply, sent once per power-up while powered
	// ------------------------------------------------------------
	int dly = 0;
	logic pwr_q = 1'b0;
	initial begin
		ss_vld = 1'b0;
		ss_value = 8'h00;
		coil_mv = 14'h0000;
		coil_vld = 1'b0;
	end
	// value line toggles when not valid so nothing stale passes
	always @(posedge clk) begin
		pwr_q <= pwr_on;
		ss_vld <= 1'b0;
		ss_value <= ~ss_value;
		if (pwr_on && !pwr_q) begin
			dly <= REPLY_DLY;
		end else if (dly > 0) begin
			dly <= dly - 1;
			if (dly == 1 && pwr_on) begin
				ss_vld <= 1'b1;
				ss_value <= reply_val;
			end
		end
	end
	// ------------------------------------------------------------
	// one coil reading; spare edge keeps calls from colliding
	// ------------------------------------------------------------
	task send_coil(input logic [13:0] v);
		@(posedge clk);
		coil_mv <= v;
		coil_vld <= 1'b1;
		@(posedge clk);
		coil_vld <= 1'b0;
		coil_mv <= ~v;
		@(posedge clk);
	endtask
endmodule

// ---- test_rail_voltage_power_control.sv ----
// self-checking bench for the rail voltage power control block
`timescale 1ns/100ps
module test_rail_voltage_power_control import rvpc_pkg::*;;
	localparam int PW = 50;
	localparam int PO = 20;
	typedef struct {logic [7:0] a; logic [31:0] d; logic e;} rvpc_row_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, coil_vld, ss_vld, pwr_on;
	logic [7:0] paddr, ss_value, freq_khz, reply_val;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] coil_mv;
	logic [14:0] rail_hmv;
	logic [1:0] guide_ind;
	logic er;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	rvpc_row_s rows[8] = '{'{ADDR_TARGET, 32'h0000_07D0, 1'b0},
		'{ADDR_SS_MIN, 32'h0000_0001, 1'b0}, '{ADDR_FSTEP, 32'h0000_0005, 1'b0},
		'{ADDR_TRIES, 32'h0000_0007, 1'b0}, '{ADDR_CTRL, 32'h0000_0000, 1'b0},
		'{ADDR_RAIL, 32'h0000_2C88, 1'b0}, '{ADDR_GUIDE, 32'h0000_0000, 1'b0},
		'{8'h24, 32'h0000_0000, 1'b1}};

	rvpc_top #(.PING_WAIT_CYCLES(PW), .PING_OFF_CYCLES(PO)) rvpc_top_i (.clk(clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.coil_mv(coil_mv), .coil_vld(coil_vld), .ss_vld(ss_vld), .ss_value(ss_value),
		.rail_hmv(rail_hmv), .freq_khz(freq_khz), .pwr_on(pwr_on), .guide_ind(guide_ind));
	rvpc_rx_model rvpc_rx_model_i (.clk(clk), .pwr_on(pwr_on), .reply_val(reply_val),
		.ss_vld(ss_vld), .ss_value(ss_value), .coil_mv(coil_mv), .coil_vld(coil_vld));

	// ------------------------------------------------------------
	// clock, hang limit and shared tasks
	// ------------------------------------------------------------
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			close_out();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one transfer; request holds until pready is sampled high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready wait", 2, k);
	endtask
	// counts cycles the power signal stays at one level
	task span(input logic lvl, output int c);
		c = 0;
		while (pwr_on === lvl && c < 500) begin
			c++;
			@(negedge clk);
		end
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		reply_val = 8'h00;
		repeat (7) @(posedge clk);
		@(negedge clk);
		chk("rail", RAIL_PING_HMV, rail_hmv);
		chk("freq", FREQ_PING_KHZ, freq_khz);
		chk("pwr", 0, pwr_on);
		@(posedge clk);
		rst_n <= 1'b1;
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, rows[i].a, 32'h0000_0000);
			chk("rdata", rows[i].d, rd);
			chk("slverr", rows[i].e, er);
		end
		apb(1'b1, ADDR_RAIL, 32'h0000_0000);
		apb(1'b0, ADDR_RAIL, 32'h0000_0000);
		chk("rail ro", 32'h0000_2C88, rd);
		apb(1'b1, ADDR_GUIDE, 32'h0000_0002);
		@(negedge clk);
		chk("guide", 2, guide_ind);
		$display("test registers done");
		// first ping gets only a weak reply, so it times out
		apb(1'b1, ADDR_SS_MIN, 32'h0000_0010);
		reply_val <= 8'h05;
		apb(1'b1, ADDR_CTRL, 32'h0000_0001);
		@(negedge clk);
		chk("pwr", 1, pwr_on);
		chk("rail", 32'h0000_2C88, rail_hmv);
		chk("freq", 140, freq_khz);
		span(1'b1, n);
		chk("wait", PW, n);
		span(1'b0, n);
		chk("off", PO, n);
		chk("freq", 135, freq_khz);
		chk("rail", 32'h0000_2C88, rail_hmv);
		@(posedge clk);
		reply_val <= 8'h20;
		repeat (30) @(negedge clk);
		chk("pwr", 1, pwr_on);
		chk("guide", 0, guide_ind);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk("state", 3, rd[1:0]);
		$display("test ping done");
		// loop: error 2000 clamps to 1500, step -0.5 mV per unit
		rvpc_rx_model_i.send_coil(14'h0000);
		@(negedge clk);
		chk("rail", 9900, rail_hmv);
		repeat (10) rvpc_rx_model_i.send_coil(14'h0FA0);
		@(negedge clk);
		chk("rail", 24000, rail_hmv);
		rvpc_rx_model_i.send_coil(14'h076C);
		@(negedge clk);
		chk("rail", 23900, rail_hmv);
		repeat (13) rvpc_rx_model_i.send_coil(14'h0000);
		@(negedge clk);
		chk("rail", 6000, rail_hmv);
		apb(1'b1, ADDR_CTRL, 32'h0000_0002);
		@(negedge clk);
		chk("pwr", 0, pwr_on);
		$display("test loop done");
		// no retries allowed: a silent ping ends in the failed idle state
		reply_val <= 8'h05;
		apb(1'b1, ADDR_TRIES, 32'h0000_0000);
		apb(1'b1, ADDR_CTRL, 32'h0000_0001);
		@(negedge clk);
		span(1'b1, n);
		chk("wait", PW, n);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk("fail", 1, rd[8]);
		chk("state", 0, rd[1:0]);
		$display("test give up done");
		close_out();
	end
endmodule
